// ==== ilfs_top.sv ====
/*
 I/O line function select: ownership, A-D select, pull-up/pull-down.
 Assumes software write strobes are one-cycle pulses on clk, with a
 one-hot-per-bit mask; pad inputs come asynchronously from pins.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ilfs_defs.svh"
module ilfs_top (
   // Clock and reset
   input  wire logic                          clk,
   input  wire logic                          rst_n,
   // Ownership control
   input  wire logic                          own_enable_wr,
   input  wire logic                          own_disable_wr,
   input  wire logic [`ILFS_NUM_LINES-1:0]    own_wdata,
   output logic      [`ILFS_NUM_LINES-1:0]    line_own_state_reg,
   // Function select
   input  wire logic                          sel_lo_wr,
   input  wire logic                          sel_hi_wr,
   input  wire logic [`ILFS_NUM_LINES-1:0]    sel_wdata,
   output logic      [`ILFS_NUM_LINES-1:0]    func_select_lo_reg,
   output logic      [`ILFS_NUM_LINES-1:0]    func_select_hi_reg,
   // Pull resistor control
   input  wire logic                          pu_enable_wr,
   input  wire logic                          pu_disable_wr,
   input  wire logic                          pd_enable_wr,
   input  wire logic                          pd_disable_wr,
   input  wire logic [`ILFS_NUM_LINES-1:0]    pull_wdata,
   output logic      [`ILFS_NUM_LINES-1:0]    pullup_state,
   output logic      [`ILFS_NUM_LINES-1:0]    pulldown_state_reg,
   // Controller output logic
   input  wire logic [`ILFS_NUM_LINES-1:0]    ctl_out,
   input  wire logic [`ILFS_NUM_LINES-1:0]    ctl_oe,
   // Peripherals: 4 per line, index line*4+func
   input  wire logic [`ILFS_NUM_LINES*4-1:0]  per_out,
   input  wire logic [`ILFS_NUM_LINES*4-1:0]  per_oe,
   output logic      [`ILFS_NUM_LINES-1:0]    per_in,
   output logic      [`ILFS_NUM_LINES-1:0]    ctl_in,
   // Pads
   input  wire logic [`ILFS_NUM_LINES-1:0]    pad_in,
   output logic      [`ILFS_NUM_LINES-1:0]    pad_out,
   output logic      [`ILFS_NUM_LINES-1:0]    pad_oe_n,
   output logic      [`ILFS_NUM_LINES-1:0]    pad_pu_en,
   output logic      [`ILFS_NUM_LINES-1:0]    pad_pd_en
);
   localparam logic [`ILFS_NUM_LINES-1:0] HAS_PERIPH = `ILFS_HAS_PERIPH;
   localparam logic [`ILFS_NUM_LINES-1:0] OWN_RESET  = `ILFS_OWN_RESET;

   ilfs_mux_if mif ();                              // Link to the output mux
   logic [`ILFS_NUM_LINES-1:0] pu_status;           // One: pull-up disabled
   logic [`ILFS_NUM_LINES-1:0] sync1, sync2, sync3; // Pad input synchroniser
   logic [`ILFS_NUM_LINES-1:0] pin_level;           // Filtered pin level

   // Ownership: enable sets, disable clears; lines without peripheral stay one
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         line_own_state_reg <= OWN_RESET | ~HAS_PERIPH;
      end else begin
         if (own_enable_wr) begin
            line_own_state_reg <= line_own_state_reg | (own_wdata & HAS_PERIPH);
         end else if (own_disable_wr) begin
            line_own_state_reg <= line_own_state_reg & ~(own_wdata & HAS_PERIPH);
         end
      end
   end

   // Select registers: written regardless of ownership, no existence check
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         func_select_lo_reg <= `ILFS_SEL_RESET;
      end else if (sel_lo_wr) begin
         func_select_lo_reg <= sel_wdata;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         func_select_hi_reg <= `ILFS_SEL_RESET;
      end else if (sel_hi_wr) begin
         func_select_hi_reg <= sel_wdata;
      end
   end

   // Pull-up status: one means disabled; enable refused while pull-down on
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pu_status <= ~`ILFS_PU_RESET;
      end else if (pu_enable_wr) begin
         // Accepted whatever the ownership or function of the line
         pu_status <= pu_status & ~(pull_wdata & pulldown_state_reg);
      end else if (pu_disable_wr) begin
         pu_status <= pu_status | pull_wdata;
      end
   end

   // Pull-down status: one means disabled; enable refused while pull-up on
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pulldown_state_reg <= ~`ILFS_PD_RESET;
      end else if (pd_enable_wr) begin
         pulldown_state_reg <= pulldown_state_reg & ~(pull_wdata & pu_status);
      end else if (pd_disable_wr) begin
         pulldown_state_reg <= pulldown_state_reg | pull_wdata;
      end
   end

   // Pad input synchroniser; level changes once stages two and three agree
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1     <= '0;
         sync2     <= '0;
         sync3     <= '0;
         pin_level <= '0;
      end else begin
         sync1 <= pad_in;
         sync2 <= sync1;
         sync3 <= sync2;
         for (int k = 0; k < `ILFS_NUM_LINES; k++) begin
            if (sync2[k] == sync3[k]) begin
               pin_level[k] <= sync3[k];
            end
         end
      end
   end

   // Every peripheral input sees the pin, whatever the selection
   assign per_in = pin_level;
   assign ctl_in = pin_level;

   // Feed the mux
   assign mif.own_ctl = line_own_state_reg;
   assign mif.sel_lo  = func_select_lo_reg;
   assign mif.sel_hi  = func_select_hi_reg;
   assign mif.per_out = per_out;
   assign mif.per_oe  = per_oe;
   assign mif.ctl_out = ctl_out;
   assign mif.ctl_oe  = ctl_oe;

   ilfs_out_mux u_mux (
      .m (mif.mux)
   );

   // Pad drive; enable low while driving
   assign pad_out      = mif.pad_out;
   assign pad_oe_n     = ~mif.pad_oe;
   assign pullup_state = pu_status;
   assign pad_pu_en    = ~pu_status;
   assign pad_pd_en    = ~pulldown_state_reg;
endmodule // ilfs_top
`default_nettype wire

// ==== ilfs_defs.svh ====
/*
 Constants for the I/O line function select block: reset values, codes
 and widths. Assumes it is included by its bare name from any file.
*/
//
// Functional notes
// - Pull-down enable ignored while pull-up on
// - Pull-up enable ignored while pull-down on
// - Pull-down writes update status, one means off
// - Pull-up writes accepted in any configuration
// - Pull states reset to per-line product values
// - Enable gives controller, disable gives peripheral
// - Lines without peripheral stay controller owned
// - Ownership reset value is per-line parameter
// - Up to four peripheral functions per pin
// - Select bits decode A, B, C, D
// - Selection steers output only, inputs shared
// - Select writes apply in any configuration
// - Selects reset zero, A idle under controller
// - Nonexistent function stored, pin undriven by it
`ifndef ILFS_DEFS_SVH
`define ILFS_DEFS_SVH
`define ILFS_NUM_LINES      32
`define ILFS_NUM_FUNCS      4
`define ILFS_OWN_RESET      32'hFFFFFFFF
`define ILFS_HAS_PERIPH     32'hFFFFFFFF
`define ILFS_PU_RESET       32'h00000000
`define ILFS_PD_RESET       32'h00000000
`define ILFS_FUNC_EXISTS    128'hFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFF
`define ILFS_SEL_RESET      32'h00000000
`endif

// ==== ilfs_pkg.sv ====
/*
 Types shared by the function select block.
 Assumes nothing beyond the constant header.
*/
`include "ilfs_defs.svh"
package ilfs_pkg;
   // Peripheral function code
   typedef enum logic [1:0] {
      ILFS_FUNC_A = 2'h0,
      ILFS_FUNC_B = 2'h1,
      ILFS_FUNC_C = 2'h2,
      ILFS_FUNC_D = 2'h3
   } ilfs_func_t;
   // One line's drive
   typedef struct packed {
      logic out;
      logic oe;
   } ilfs_drive_t;
endpackage : ilfs_pkg

// ==== ilfs_mux_if.sv ====
/*
 Carries per-line selection and drive between top and the output mux.
 Assumes one instance per block.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ilfs_defs.svh"
interface ilfs_mux_if;
   logic [`ILFS_NUM_LINES-1:0]   own_ctl;   // One: controller owns line
   logic [`ILFS_NUM_LINES-1:0]   sel_lo;    // First select bit
   logic [`ILFS_NUM_LINES-1:0]   sel_hi;    // Second select bit
   logic [`ILFS_NUM_LINES*4-1:0] per_out;   // Peripheral outputs, 4 per line
   logic [`ILFS_NUM_LINES*4-1:0] per_oe;    // Peripheral enables, high drives
   logic [`ILFS_NUM_LINES-1:0]   ctl_out;   // Controller output value
   logic [`ILFS_NUM_LINES-1:0]   ctl_oe;    // Controller enable, high drives
   logic [`ILFS_NUM_LINES-1:0]   pad_out;   // Muxed pad value
   logic [`ILFS_NUM_LINES-1:0]   pad_oe;    // Muxed enable, high drives
   modport top (output own_ctl, sel_lo, sel_hi, per_out, per_oe, ctl_out, ctl_oe,
                input pad_out, pad_oe);
   modport mux (input own_ctl, sel_lo, sel_hi, per_out, per_oe, ctl_out, ctl_oe,
                output pad_out, pad_oe);
endinterface : ilfs_mux_if
`default_nettype wire

// ==== ilfs_out_mux.sv ====
/*
 Per-line output multiplexer for pads, combinational.
 Assumes the top registers every select and ownership bit.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ilfs_defs.svh"
module ilfs_out_mux (
   ilfs_mux_if.mux m
);
   localparam logic [`ILFS_NUM_LINES*4-1:0] EXISTS = `ILFS_FUNC_EXISTS;

   // Decode two select bits to a function index
   function automatic ilfs_pkg::ilfs_func_t ilfs_decode(input logic lo, input logic hi);
      ilfs_decode = ilfs_pkg::ilfs_func_t'({hi, lo});
   endfunction

   genvar i;
   generate
      for (i = 0; i < `ILFS_NUM_LINES; i++) begin : g_line
         ilfs_pkg::ilfs_func_t f;
         logic [1:0]           idx;
         assign f   = ilfs_decode(m.sel_lo[i], m.sel_hi[i]);
         assign idx = 2'(f);
         // Peripheral path only when it owns the line and the function exists
         always_comb begin
            if (m.own_ctl[i]) begin
               m.pad_out[i] = m.ctl_out[i];
               m.pad_oe[i]  = m.ctl_oe[i];
            end else if (EXISTS[i*4+idx]) begin
               m.pad_out[i] = m.per_out[i*4+idx];
               m.pad_oe[i]  = m.per_oe[i*4+idx];
            end else begin
               m.pad_out[i] = 1'b0;
               m.pad_oe[i]  = 1'b0;
            end
         end
      end
   endgenerate
endmodule // ilfs_out_mux
`default_nettype wire

// ==== ilfs_props.sv ====
/* Assertions on the function select top ports.
 Assumes one clock domain and the constant header. */
`timescale 1ns/1ps
`default_nettype none
`include "ilfs_defs.svh"
module ilfs_props #(parameter int N = `ILFS_NUM_LINES) (
   // Clock, reset and strobes
   input wire logic clk, rst_n, own_enable_wr, own_disable_wr, sel_lo_wr,
   input wire logic pu_enable_wr, pd_enable_wr, pd_disable_wr,
   // Write data and drive inputs
   input wire logic [N-1:0] own_wdata, sel_wdata, pull_wdata, ctl_out, ctl_oe, pad_in,
   input wire logic [4*N-1:0] per_out, per_oe,
   // State and pad outputs
   input wire logic [N-1:0] line_own_state_reg, func_select_lo_reg, func_select_hi_reg,
   input wire logic [N-1:0] pullup_state, pulldown_state_reg, per_in, pad_out, pad_oe_n,
   input wire logic [N-1:0] pad_pu_en
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire logic [1:0] f0 = {func_select_hi_reg[0], func_select_lo_reg[0]}; // Line 0 code
   // Pin must sit still long enough for the synchroniser
   sequence s_pin_high; pad_in[0] [*6]; endsequence
   property p_pd_refused; pd_enable_wr && pull_wdata[0] && !pullup_state[0] |=> pulldown_state_reg[0]; endproperty
   a_pd_refused: assert property (p_pd_refused) else $error("pull-down taken over pull-up");
   property p_pu_refused; pu_enable_wr && pull_wdata[0] && !pulldown_state_reg[0] |=> pullup_state[0]; endproperty
   a_pu_refused: assert property (p_pu_refused) else $error("pull-up taken over pull-down");
   property p_pd_on; pd_enable_wr && pull_wdata[0] && pullup_state[0] && !pu_enable_wr |=> !pulldown_state_reg[0]; endproperty
   a_pd_on: assert property (p_pd_on) else $error("pull-down enable lost");
   property p_own_on; own_enable_wr && own_wdata[0] |=> line_own_state_reg[0]; endproperty
   a_own_on: assert property (p_own_on) else $error("controller ownership lost");
   property p_own_off; own_disable_wr && !own_enable_wr && own_wdata[0] |=> !line_own_state_reg[0]; endproperty
   a_own_off: assert property (p_own_off) else $error("peripheral ownership lost");
   property p_sel; sel_lo_wr |=> func_select_lo_reg == $past(sel_wdata); endproperty
   a_sel: assert property (p_sel) else $error("select write lost");
   property p_pad; line_own_state_reg[0] ? (pad_out[0] == ctl_out[0] && pad_oe_n[0] != ctl_oe[0])
      : (pad_out[0] == per_out[f0] && pad_oe_n[0] != per_oe[f0]); endproperty
   a_pad: assert property (p_pad) else $error("pad drive from wrong source");
   property p_pin; s_pin_high |-> per_in[0]; endproperty
   a_pin: assert property (p_pin) else $error("pin level not seen by peripheral");
   property p_reset; $rose(rst_n) |-> line_own_state_reg == `ILFS_OWN_RESET && func_select_hi_reg == '0
      && pad_pu_en == `ILFS_PU_RESET; endproperty
   a_reset: assert property (p_reset) else $error("bad state after reset");
endmodule // ilfs_props
bind ilfs_top ilfs_props ilfs_props_inst (.clk, .rst_n, .own_enable_wr, .own_disable_wr,
   .sel_lo_wr, .pu_enable_wr, .pd_enable_wr, .pd_disable_wr, .own_wdata, .sel_wdata, .pull_wdata,
   .ctl_out, .ctl_oe, .pad_in, .per_out, .per_oe, .line_own_state_reg, .func_select_lo_reg,
   .func_select_hi_reg, .pullup_state, .pulldown_state_reg, .per_in, .pad_out, .pad_oe_n, .pad_pu_en);
`default_nettype wire

// ==== ilfs_periph_model.sv ====
/* Peripherals and pins around the block.
 Assumes the bench seeds the random source. */
`timescale 1ns/1ps
`default_nettype none
`include "ilfs_defs.svh"
module ilfs_periph_model (
   // Clock
   input  wire logic                         clk,
   // Peripheral drive and pin level
   output logic      [`ILFS_NUM_LINES*4-1:0] per_out,
   output logic      [`ILFS_NUM_LINES*4-1:0] per_oe,
   output logic      [`ILFS_NUM_LINES-1:0]   pad_in
);
   int unsigned cnt = 0; // Cycle count
   initial {per_out, per_oe, pad_in} = '0;
   // Peripherals take new random values every cycle; pins hold 8 cycles so the synchroniser settles
   always @(posedge clk) begin
      per_out <= {$urandom, $urandom, $urandom, $urandom};
      per_oe <= {$urandom, $urandom, $urandom, $urandom};
      cnt <= cnt + 1;
      if (cnt % 8 == 0) pad_in <= $urandom;
   end
endmodule // ilfs_periph_model
`default_nettype wire

// ==== tb.sv ====
/* Self-checking bench for the function select block.
 Assumes the partner model drives peripheral and pin inputs. */
`timescale 1ns/1ps
`default_nettype none
`include "ilfs_defs.svh"
module tb;
   localparam int N = `ILFS_NUM_LINES;
   logic clk = 0, rst_n = 0, pend = 0, rchk = 0;
   logic [7:0] stb = '0; // own en/dis, sel lo/hi, pu en/dis, pd en/dis
   logic [N-1:0] d = '0, c_out = '0, c_oe = '0, own, lo, hi, pu, pd;
   logic [N-1:0] own_q, lo_q, hi_q, pu_q, pd_q, pad_in, pad_out, pad_oe_n, pad_pu_en, pad_pd_en;
   logic [N-1:0] per_in, ctl_in, pin_prev = '0; // Synchronised pin level and last sampled pins
   int pin_age = -1; // Edges the sampled pins have held still since reset or a change
   logic [4*N-1:0] per_out, per_oe;
   logic [5*N-1:0] exp_q[$]; // Expected state, oldest first
   int errors = 0, tests_run = 0;
   logic [7:0] kinds [12] = '{8'h80, 8'h40, 8'hC0, 8'h20, 8'h10, 8'h30, 8'h08, 8'h04, 8'h0C,
      8'h02, 8'h01, 8'h03};
   always #5 clk = ~clk;
   ilfs_top ilfs_top_inst (.clk, .rst_n, .own_enable_wr(stb[7]), .own_disable_wr(stb[6]),
      .own_wdata(d), .line_own_state_reg(own_q), .sel_lo_wr(stb[5]), .sel_hi_wr(stb[4]),
      .sel_wdata(d), .func_select_lo_reg(lo_q), .func_select_hi_reg(hi_q), .pu_enable_wr(stb[3]),
      .pu_disable_wr(stb[2]), .pd_enable_wr(stb[1]), .pd_disable_wr(stb[0]), .pull_wdata(d),
      .pullup_state(pu_q), .pulldown_state_reg(pd_q), .ctl_out(c_out), .ctl_oe(c_oe), .per_out,
      .per_oe, .per_in, .ctl_in, .pad_in, .pad_out, .pad_oe_n, .pad_pu_en, .pad_pd_en);
   ilfs_periph_model ilfs_periph_model_inst (.clk, .per_out, .per_oe, .pad_in);
   task automatic chk(string name, logic [N-1:0] seen, logic [N-1:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // One write; enable wins over disable, pull enable refused against the other resistor
   task automatic wr(logic [7:0] s, logic [N-1:0] v);
      logic [N-1:0] pu0, pd0;
      pu0 = pu;
      pd0 = pd;
      @(posedge clk);
      stb <= s; d <= v; c_out <= $urandom; c_oe <= $urandom;
      if (s[7]) own |= v; else if (s[6]) own &= ~v;
      if (s[5]) lo = v;
      if (s[4]) hi = v;
      if (s[3]) pu &= ~(v & pd0); else if (s[2]) pu |= v;
      if (s[1]) pd &= ~(v & pu0); else if (s[0]) pd |= v;
      exp_q.push_back({own, lo, hi, pu, pd});
   endtask
   task automatic rst(int n);
      // Let the last write land and be compared before reset clears the state
      @(posedge clk) stb <= '0;
      @(posedge clk) rst_n <= 0;
      repeat (n) @(posedge clk);
      rst_n <= 1; rchk <= 1;
      own = `ILFS_OWN_RESET; lo = '0; hi = '0; pu = ~`ILFS_PU_RESET; pd = ~`ILFS_PD_RESET;
      exp_q.push_back({own, lo, hi, pu, pd});
      @(posedge clk) rchk <= 0;
   endtask
   task automatic final_report();
      if (errors == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Results land one edge after the write; compare on the falling edge after that
   always @(posedge clk) pend <= |stb;
   // Pin history: the level reaches the peripherals after four still samples
   always @(posedge clk) begin
      pin_prev <= pad_in;
      if (!rst_n) pin_age <= -1;
      else if (pad_in != pin_prev) pin_age <= 0;
      else pin_age <= pin_age + 1;
   end
   always @(negedge clk) if (rst_n && pin_age >= 3) begin
      chk("per_in", per_in, pin_prev);
      chk("ctl_in", ctl_in, pin_prev);
   end
   always @(negedge clk) if (pend || rchk) begin
      logic [N-1:0] eo, el, eh, eu, ed, xo, xe;
      logic [1:0] f;
      {eo, el, eh, eu, ed} = exp_q.pop_front();
      for (int i = 0; i < N; i++) begin
         f = {eh[i], el[i]};
         xo[i] = eo[i] ? c_out[i] : per_out[i*4+f];
         xe[i] = eo[i] ? !c_oe[i] : !per_oe[i*4+f];
      end
      chk("own", own_q, eo);
      chk("sel_lo", lo_q, el);
      chk("sel_hi", hi_q, eh);
      chk("pullup", pu_q, eu);
      chk("pulldown", pd_q, ed);
      chk("pad_out", pad_out, xo);
      chk("pad_oe_n", pad_oe_n, xe);
      chk("pad_pu_en", pad_pu_en, ~eu);
      chk("pad_pd_en", pad_pd_en, ~ed);
   end
   initial begin
      #100000 errors++;
      final_report();
   end
   initial begin
      void'($urandom(40));
      rst(20);
      wr(8'h08, '1); wr(8'h02, '1); wr(8'h04, '1); wr(8'h02, '1); wr(8'h08, '1);
      for (int k = 0; k < 4; k++) begin
         wr(8'h20, k[0] ? '1 : '0); wr(8'h10, k[1] ? '1 : '0); wr(8'h40, '1); wr(8'h80, '1);
      end
      repeat (300) wr(kinds[$urandom % 12], $urandom);
      rst(3);
      repeat (50) wr(kinds[$urandom % 12], $urandom);
      @(posedge clk) stb <= '0;
      repeat (3) @(posedge clk);
      final_report();
   end
endmodule // tb
`default_nettype wire
